// File: logic/enhanced_watchdog_timer.sv
// guard timer top: registers, change window, counter and expiry actions
//
// The register addresses and the AXI4-Lite slave port were decided locally.
module enhanced_watchdog_timer #(
	parameter int OSC_DIV = guard_pkg::OSC_DIV_CYC,
	parameter int WIN_CYC = guard_pkg::CHANGE_WIN_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [guard_pkg::ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [guard_pkg::DATA_W-1:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// axi4-lite write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read
	input wire logic [guard_pkg::ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [guard_pkg::DATA_W-1:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// fuse strap, high when programmed
	input wire logic always_on_fuse,
	// interrupt request and system reset
	output logic guard_irq,
	output logic sys_reset
);
	guard_regs_if regs ();

	logic tick;
	guard_pkg::win_state_t win_r;
	logic [2:0] win_cnt_r;
	logic sys_reset_enable_r;
	logic guard_irq_enable_r;
	logic [3:0] timeout_prescale_r;
	logic irq_flag_r;
	logic [1:0] div_sel_r;
	logic div_sel2_r;
	logic ew_enable_r;
	logic ew_flag_r;
	logic ew_clear_mode_r;
	logic guard_reset_flag_r;
	logic restart_pend_r;
	logic [guard_pkg::CNT_W-1:0] cnt_r;
	logic [guard_pkg::CNT_W-1:0] cnt_inc;
	logic [guard_pkg::CNT_W-1:0] timeout;
	logic ctrl_wr;
	logic ckd_wr;
	logic cause_wr;
	logic cmd_wr;
	logic unlock_wr;
	logic win_open;
	logic protected_ok;
	logic re_eff;
	logic ie_eff;
	logic running;
	logic expiry1;
	logic expiry2;
	logic fire_reset;
	logic irq_ack;
	logic ew_ack;
	logic [7:0] ctrl_rd;
	logic [7:0] ckd_rd;

	////////////////////////////////////////////////////////////////////
	// sub blocks

	guard_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_awaddr),
		.awvalid(s_awvalid),
		.awready(s_awready),
		.wdata(s_wdata),
		.wstrb(s_wstrb),
		.wvalid(s_wvalid),
		.wready(s_wready),
		.bresp(s_bresp),
		.bvalid(s_bvalid),
		.bready(s_bready),
		.araddr(s_araddr),
		.arvalid(s_arvalid),
		.arready(s_arready),
		.rdata(s_rdata),
		.rresp(s_rresp),
		.rvalid(s_rvalid),
		.rready(s_rready),
		.regs(regs)
	);

	// divided oscillator rate drives the counter
	guard_tick #(
		.OSC_DIV(OSC_DIV)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.div_sel(div_sel_r),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////
	// write decode

	// register strobes
	assign ctrl_wr = regs.we
		&& (regs.waddr == guard_pkg::reg_addr(guard_pkg::CTRL_IDX));
	assign ckd_wr = regs.we
		&& (regs.waddr == guard_pkg::reg_addr(guard_pkg::CKD_IDX));
	assign cause_wr = regs.we
		&& (regs.waddr == guard_pkg::reg_addr(guard_pkg::CAUSE_IDX));
	assign cmd_wr = regs.we
		&& (regs.waddr == guard_pkg::reg_addr(guard_pkg::CMD_IDX));

	// unlock needs both bits in the same write
	assign unlock_wr = ctrl_wr && regs.wdata[guard_pkg::CTRL_CE]
		&& regs.wdata[guard_pkg::CTRL_RE];
	assign win_open = (win_r == guard_pkg::WIN_OPEN);
	// the follow-up write must have change enable cleared
	assign protected_ok = win_open && !regs.wdata[guard_pkg::CTRL_CE];

	// vector-taken strobes, written through the command register
	assign irq_ack = cmd_wr && regs.wdata[guard_pkg::CMD_IRQ_ACK];
	assign ew_ack = cmd_wr && regs.wdata[guard_pkg::CMD_EW_ACK];

	////////////////////////////////////////////////////////////////////
	// change window

	// closes by itself after the window so a stray write cannot use it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_r <= guard_pkg::WIN_LOCKED;
			win_cnt_r <= '0;
		end else begin
			case (win_r)
				guard_pkg::WIN_LOCKED: begin
					if (unlock_wr) begin
						win_r <= guard_pkg::WIN_OPEN;
						win_cnt_r <= 3'(WIN_CYC - 1);
					end
				end
				guard_pkg::WIN_OPEN: begin
					if (unlock_wr) begin
						win_cnt_r <= 3'(WIN_CYC - 1);
					end else if (win_cnt_r == 3'h0) begin
						win_r <= guard_pkg::WIN_LOCKED;
					end else begin
						win_cnt_r <= win_cnt_r - 3'h1;
					end
				end
				default: begin
					win_r <= guard_pkg::WIN_LOCKED;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode bits

	// reset enable: set freely, cleared only inside the window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_reset_enable_r <= 1'b0;
		end else if (always_on_fuse) begin
			sys_reset_enable_r <= 1'b1;
		end else if (guard_reset_flag_r) begin
			sys_reset_enable_r <= 1'b1;
		end else if (ctrl_wr && regs.wdata[guard_pkg::CTRL_RE]) begin
			sys_reset_enable_r <= 1'b1;
		end else if (ctrl_wr && protected_ok) begin
			sys_reset_enable_r <= 1'b0;
		end
	end

	// interrupt enable is not protected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_irq_enable_r <= 1'b0;
		end else if (always_on_fuse) begin
			guard_irq_enable_r <= 1'b0;
		end else if (ctrl_wr) begin
			guard_irq_enable_r <= regs.wdata[guard_pkg::CTRL_IE];
		end else if (irq_ack && re_eff) begin
			guard_irq_enable_r <= 1'b0;
		end
	end

	// prescale only changes in the window; others are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_prescale_r <= '0;
		end else if (ctrl_wr && protected_ok) begin
			timeout_prescale_r <= {regs.wdata[guard_pkg::CTRL_WDP3],
				regs.wdata[2:0]};
		end
	end

	// divider select and early warning controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_sel_r <= '0;
			div_sel2_r <= 1'b0;
			ew_enable_r <= 1'b0;
			ew_clear_mode_r <= 1'b0;
		end else if (ckd_wr) begin
			ew_enable_r <= regs.wdata[guard_pkg::CKD_EWE];
			ew_clear_mode_r <= regs.wdata[guard_pkg::CKD_EWCM];
			if (win_open) begin
				div_sel_r <= regs.wdata[1:0];
				div_sel2_r <= regs.wdata[guard_pkg::CKD_SEL2];
			end
		end
	end

	assign re_eff = sys_reset_enable_r || guard_reset_flag_r
		|| always_on_fuse;
	assign ie_eff = guard_irq_enable_r && !always_on_fuse;
	assign running = re_eff || ie_eff || ew_enable_r;

	////////////////////////////////////////////////////////////////////
	// counter

	// reserved prescale codes saturate at the longest time-out
	assign timeout = (timeout_prescale_r > 4'(guard_pkg::PRESCALE_MAX))
		? (guard_pkg::CNT_W)'(guard_pkg::BASE_TIMEOUT)
			<< guard_pkg::PRESCALE_MAX
		: (guard_pkg::CNT_W)'(guard_pkg::BASE_TIMEOUT)
			<< timeout_prescale_r;
	assign cnt_inc = cnt_r + (guard_pkg::CNT_W)'(1);
	assign expiry1 = tick && running && !restart_pend_r
		&& (cnt_inc == timeout);
	assign expiry2 = tick && running && !restart_pend_r
		&& (cnt_inc == (timeout << 1));

	// restart is held until the next slow tick; a new one wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_pend_r <= 1'b0;
		end else if (cmd_wr && regs.wdata[guard_pkg::CMD_RESTART]) begin
			restart_pend_r <= 1'b1;
		end else if (tick) begin
			restart_pend_r <= 1'b0;
		end
	end

	// counts slow ticks, wraps after the double time-out
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			cnt_r <= '0;
		end else if (tick) begin
			if (restart_pend_r || expiry2) begin
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_inc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// expiry actions

	// pending interrupt in combined mode falls through to a reset
	assign fire_reset = expiry2 && re_eff
		&& (!ie_eff || irq_flag_r);

	// interrupt flag: set wins over the software or vector clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag_r <= 1'b0;
		end else if (expiry2 && ie_eff && !fire_reset) begin
			irq_flag_r <= 1'b1;
		end else if (ctrl_wr && regs.wdata[guard_pkg::CTRL_IRQF]) begin
			irq_flag_r <= 1'b0;
		end else if (irq_ack) begin
			irq_flag_r <= 1'b0;
		end
	end

	// early warning flag, independent of the mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ew_flag_r <= 1'b0;
		end else if (expiry1 && ew_enable_r) begin
			ew_flag_r <= 1'b1;
		end else if (ckd_wr && regs.wdata[guard_pkg::CKD_EWF]) begin
			ew_flag_r <= 1'b0;
		end else if (ew_ack && !ew_clear_mode_r) begin
			ew_flag_r <= 1'b0;
		end
	end

	// one-cycle system reset pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_reset <= 1'b0;
		end else begin
			sys_reset <= fire_reset;
		end
	end

	// reset cause flag survives the pulse; cleared by writing zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_reset_flag_r <= 1'b0;
		end else if (fire_reset) begin
			guard_reset_flag_r <= 1'b1;
		end else if (cause_wr && !regs.wdata[guard_pkg::CAUSE_FLAG]) begin
			guard_reset_flag_r <= 1'b0;
		end
	end

	// level request, also the wake source out of sleep
	assign guard_irq = (ie_eff && irq_flag_r)
		|| (ew_enable_r && ew_flag_r);

	////////////////////////////////////////////////////////////////////
	// read back

	assign ctrl_rd = {irq_flag_r, ie_eff, timeout_prescale_r[3],
		win_open, re_eff, timeout_prescale_r[2:0]};
	assign ckd_rd = {2'h0, ew_clear_mode_r, div_sel2_r, ew_flag_r,
		ew_enable_r, div_sel_r};

	// combinational mux; the bus slave registers the result
	always_comb begin
		regs.rdata = '0;
		if (regs.raddr == guard_pkg::reg_addr(guard_pkg::CTRL_IDX)) begin
			regs.rdata[7:0] = ctrl_rd;
		end else if (regs.raddr
			== guard_pkg::reg_addr(guard_pkg::CKD_IDX)) begin
			regs.rdata[7:0] = ckd_rd;
		end else if (regs.raddr
			== guard_pkg::reg_addr(guard_pkg::CAUSE_IDX)) begin
			regs.rdata[guard_pkg::CAUSE_FLAG] = guard_reset_flag_r;
		end else if (regs.raddr
			== guard_pkg::reg_addr(guard_pkg::COUNT_IDX)) begin
			regs.rdata[guard_pkg::CNT_W-1:0] = cnt_r;
		end
	end
endmodule

// File: logic/guard_axil.sv
// axi4-lite slave that turns bus transfers into register strobes
module guard_axil (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address and data
	input wire logic [guard_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [guard_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [guard_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [guard_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// core side
	guard_regs_if.bus regs
);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	logic wr_go;
	logic rd_go;

	// address and data are taken together; simpler than two holding regs
	assign wr_go = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready = wr_go;
	assign rd_go = arvalid && !rvalid;
	assign arready = rd_go;

	// only the low byte lane carries register data
	assign regs.we = wr_go && wstrb[0] && guard_pkg::reg_known(awaddr);
	assign regs.waddr = awaddr;
	assign regs.wdata = wdata[7:0];
	assign regs.raddr = araddr;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= guard_pkg::reg_known(awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read data, unmapped reads return zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rdata <= regs.rdata;
			rresp <= guard_pkg::reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// File: logic/guard_pkg.sv
// shared constants, register map and types of the guard timer
package guard_pkg;

	// bus and data widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// clock rates and derived cycle counts
	localparam int CLK_HZ = 125_000_000;
	localparam int OSC_HZ = 128_000;
	localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
	localparam int CHANGE_WIN_CYC = 4;
	localparam int TIMEOUT_MIN_MS = 16;
	localparam int TIMEOUT_MAX_S = 8;
	localparam int BASE_TIMEOUT = TIMEOUT_MIN_MS * OSC_HZ / 1000;
	localparam int PRESCALE_MAX = 9;
	localparam int CNT_W = 22;

	// register indices; the byte address is four times the index
	localparam logic [ADDR_W-1:0] CAUSE_IDX = 12'h054;
	localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h060;
	localparam logic [ADDR_W-1:0] CKD_IDX = 12'h062;
	localparam logic [ADDR_W-1:0] CMD_IDX = 12'h070;
	localparam logic [ADDR_W-1:0] COUNT_IDX = 12'h071;

	// control register fields
	localparam int CTRL_IRQF = 7;
	localparam int CTRL_IE = 6;
	localparam int CTRL_WDP3 = 5;
	localparam int CTRL_CE = 4;
	localparam int CTRL_RE = 3;

	// clock divider register fields
	localparam int CKD_EWCM = 5;
	localparam int CKD_SEL2 = 4;
	localparam int CKD_EWF = 3;
	localparam int CKD_EWE = 2;

	// reset cause and command fields
	localparam int CAUSE_FLAG = 3;
	localparam int CMD_RESTART = 0;
	localparam int CMD_IRQ_ACK = 1;
	localparam int CMD_EW_ACK = 2;

	// change window states
	typedef enum logic [1:0] {
		WIN_LOCKED = 2'h1,
		WIN_OPEN = 2'h2
	} win_state_t;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(
		input logic [ADDR_W-1:0] idx);
		reg_addr = {idx[ADDR_W-3:0], 2'h0};
	endfunction

	// true for any mapped register address
	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		reg_known = (a == reg_addr(CAUSE_IDX)) || (a == reg_addr(CTRL_IDX))
			|| (a == reg_addr(CKD_IDX)) || (a == reg_addr(CMD_IDX))
			|| (a == reg_addr(COUNT_IDX));
	endfunction

endpackage

// File: logic/guard_regs_if.sv
// register access signals between bus slave and timer core
interface guard_regs_if;
	logic we;
	logic [guard_pkg::ADDR_W-1:0] waddr;
	logic [7:0] wdata;
	logic [guard_pkg::ADDR_W-1:0] raddr;
	logic [guard_pkg::DATA_W-1:0] rdata;

	modport bus (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport core (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// File: logic/guard_tick.sv
// oscillator rate enable and odd source divider for the guard timer
module guard_tick #(
	parameter int OSC_DIV = guard_pkg::OSC_DIV_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// divider select: factor 1, 3, 5 or 7
	input wire logic [1:0] div_sel,
	// one pulse per divided oscillator period
	output logic tick
);
	logic [15:0] osc_cnt_r;
	logic [2:0] odd_cnt_r;
	logic osc_en;
	logic [2:0] odd_last;

	assign osc_en = (osc_cnt_r == 16'(OSC_DIV - 1));
	assign odd_last = {div_sel, 1'b0};

	// stands in for the free-running on-chip oscillator
	always_ff @(posedge aclk) begin
		if (!aresetn || osc_en) begin
			osc_cnt_r <= '0;
		end else begin
			osc_cnt_r <= osc_cnt_r + 16'h1;
		end
	end

	// odd divider, a select change applies to the period already counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			odd_cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (osc_en) begin
				if (odd_cnt_r >= odd_last) begin
					odd_cnt_r <= '0;
					tick <= 1'b1;
				end else begin
					odd_cnt_r <= odd_cnt_r + 3'h1;
				end
			end
		end
	end
endmodule

// File: tb/guard_properties.sv
// concurrent checks on the guard timer top ports
module guard_properties #(
	parameter int OSC_DIV = guard_pkg::OSC_DIV_CYC,
	parameter int WIN_CYC = guard_pkg::CHANGE_WIN_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus side
	input wire logic [guard_pkg::ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [guard_pkg::ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [guard_pkg::DATA_W-1:0] s_rdata,
	input wire logic s_rvalid,
	input wire logic s_rready,
	// strap and outputs
	input wire logic always_on_fuse,
	input wire logic sys_reset
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// unmapped write address, judged from the fixed map
	logic unmapped;
	assign unmapped = s_awaddr != 12'h150 && s_awaddr != 12'h180
		&& s_awaddr != 12'h188 && s_awaddr != 12'h1C0
		&& s_awaddr != 12'h1C4;

	// transfer acceptance steps
	sequence s_wr_taken;
		s_awvalid && s_wvalid && !s_bvalid;
	endsequence
	sequence s_rd_taken;
		s_arvalid && !s_rvalid;
	endsequence

	a_wr_answer: assert property (s_wr_taken |=> s_bvalid)
		else $error("write not answered next cycle");
	a_wr_ready: assert property (
		s_awready == (s_awvalid && s_wvalid && !s_bvalid))
		else $error("write ready wrong");
	a_wdata_ready: assert property (s_wready == s_awready)
		else $error("write data ready differs from address ready");
	a_wr_holds: assert property (
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped early");
	a_wr_resp_code: assert property (
		s_wr_taken |=> s_bresp == {$past(unmapped), 1'b0})
		else $error("write response code wrong");
	a_no_stray_b: assert property (
		!s_bvalid && !(s_awvalid && s_wvalid) |=> !s_bvalid)
		else $error("write response without request");
	a_rd_answer: assert property (s_rd_taken |=> s_rvalid)
		else $error("read not answered next cycle");
	a_rd_ready: assert property (s_arready == (s_arvalid && !s_rvalid))
		else $error("read ready wrong");
	a_rd_holds: assert property (
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped early");
	a_fuse_mode: assert property (
		s_rd_taken ##0 (s_araddr == 12'h180 && always_on_fuse)
		|=> s_rdata[3] && !s_rdata[6])
		else $error("fuse does not force reset mode");
	a_reset_pulse: assert property (sys_reset |=> !sys_reset [*8])
		else $error("system reset not a single pulse");
	a_quiet_start: assert property (
		$rose(aresetn) |-> !sys_reset && !s_bvalid && !s_rvalid)
		else $error("outputs active after reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind enhanced_watchdog_timer guard_properties #(.OSC_DIV(OSC_DIV),
	.WIN_CYC(WIN_CYC)) i_guard_properties (.aclk(aclk), .aresetn(aresetn),
	.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
	.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
	.s_arvalid(s_arvalid),
	.s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
	.s_rready(s_rready), .always_on_fuse(always_on_fuse),
	.sys_reset(sys_reset));

// File: tb/tb_top.sv
// self-checking bench of the guard timer through its bus
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CAUSE = 12'h150;
	localparam logic [11:0] A_CTRL = 12'h180;
	localparam logic [11:0] A_CKD = 12'h188;
	localparam logic [11:0] A_CMD = 12'h1C0;
	localparam logic [11:0] A_CNT = 12'h1C4;
	// one bus case: write flag, address, data, response, read flag, value
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [7:0] d;
		logic [1:0] b;
		logic r;
		logic [7:0] e;
	} row_t;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic always_on_fuse, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic guard_irq, sys_reset;
	logic [guard_pkg::ADDR_W-1:0] s_awaddr, s_araddr;
	logic [guard_pkg::DATA_W-1:0] s_wdata, s_rdata;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, b;
	logic [31:0] d;
	// lag: cycles the response ready is held back, zero for most transfers
	int n_mismatch, compares, n, lag;
	// write, read-back rows; short window between unlock and change
	row_t rows[16] = '{
		'{0, A_CTRL, 8'h00, 2'h0, 1, 8'h00},
		'{0, A_CKD, 8'h00, 2'h0, 1, 8'h00},
		'{0, A_CNT, 8'h00, 2'h0, 1, 8'h00},
		'{1, 12'h004, 8'h01, 2'h2, 0, 8'h00},
		'{1, A_CTRL, 8'h07, 2'h0, 1, 8'h00},
		'{1, A_CKD, 8'h03, 2'h0, 1, 8'h00},
		'{1, A_CTRL, 8'h18, 2'h0, 0, 8'h00},
		'{1, A_CTRL, 8'h0D, 2'h0, 1, 8'h0D},
		'{1, A_CTRL, 8'h18, 2'h0, 0, 8'h00},
		'{1, A_CKD, 8'h01, 2'h0, 1, 8'h01},
		'{1, A_CTRL, 8'h00, 2'h0, 1, 8'h0D},
		'{1, A_CMD, 8'h01, 2'h0, 1, 8'h00},
		'{1, A_CTRL, 8'h18, 2'h0, 0, 8'h00},
		'{1, A_CKD, 8'h00, 2'h0, 0, 8'h00},
		'{1, A_CTRL, 8'h18, 2'h0, 0, 8'h00},
		'{1, A_CTRL, 8'h08, 2'h0, 1, 8'h08}
	};

	// reduced oscillator divide keeps the time-outs short
	enhanced_watchdog_timer #(
		.OSC_DIV(4),
		.WIN_CYC(4)
	) i_enhanced_watchdog_timer (
		.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .always_on_fuse(always_on_fuse),
		.guard_irq(guard_irq), .sys_reset(sys_reset));

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// compare with four-state equality
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// a wait that ran out is a failure, then stop
	task automatic timeout;
		chk(32'h0, 32'h1);
		finish_test();
	endtask

	// one write; valids held until ready, bready until bvalid
	task automatic wr(input logic [11:0] a, input logic [7:0] v,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= {24'h0, v};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= (lag == 0);
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (s_awready !== 1'b1 && i < 100);
		if (s_awready !== 1'b1) timeout();
		s_awvalid <= 1'b0;
		s_wvalid <= 1'b0;
		// a late ready leaves the answer standing; one edge must take it
		if (lag > 0) begin
			repeat (lag) @(posedge aclk);
			s_bready <= 1'b1;
			@(posedge aclk);
		end
		while (s_bvalid !== 1'b1 && i < 200) begin
			@(posedge aclk);
			i++;
		end
		if (s_bvalid !== 1'b1) timeout();
		r = s_bresp;
		s_bready <= 1'b0;
	endtask

	task automatic w(input logic [11:0] a, input logic [7:0] v);
		logic [1:0] r;
		wr(a, v, r);
	endtask

	// one read, same holding discipline
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		int i;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= (lag == 0);
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (s_arready !== 1'b1 && i < 100);
		if (s_arready !== 1'b1) timeout();
		s_arvalid <= 1'b0;
		if (lag > 0) begin
			repeat (lag) @(posedge aclk);
			s_rready <= 1'b1;
			@(posedge aclk);
		end
		while (s_rvalid !== 1'b1 && i < 200) begin
			@(posedge aclk);
			i++;
		end
		if (s_rvalid !== 1'b1) timeout();
		v = s_rdata;
		s_rready <= 1'b0;
	endtask

	// settle past the change window, then read and compare
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] v;
		repeat (8) @(posedge aclk);
		rd(a, v);
		chk(v, {24'h0, e});
	endtask

	// cycles until the chosen output goes high, bounded
	task automatic wait_out(input bit rst, input int lim, output int c);
		c = 0;
		do begin @(posedge aclk); c++; end
		while ((rst ? sys_reset : guard_irq) !== 1'b1 && c < lim);
		if (c >= lim) timeout();
	endtask

	////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// main sequence
	initial begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata, always_on_fuse} = '0;
		s_wstrb = 4'hF;
		n_mismatch = 0;
		compares = 0;
		lag = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].w) begin
				wr(rows[k].a, rows[k].d, b);
				chk(32'(b), 32'(rows[k].b));
			end
			if (rows[k].r) rchk(rows[k].a, rows[k].e);
		end
		// late ready on both answers, unmapped address both ways
		lag = 2;
		wr(12'h004, 8'h01, b);
		chk(32'(b), 32'h2);
		rd(12'h004, d);
		chk(32'(s_rresp), 32'h2);
		chk(d, 32'h0);
		lag = 0;
		// reset mode: restarts spanning more than twice T keep it quiet
		n = 0;
		repeat (3) begin
			w(A_CMD, 8'h01);
			repeat (6000) begin
				@(posedge aclk);
				if (sys_reset !== 1'b0) n++;
			end
		end
		chk(32'(n), 32'h0);
		w(A_CMD, 8'h01);
		wait_out(1, 16600, n);
		chk(32'(n >= 16370 && n <= 16400), 32'h1);
		rchk(A_CAUSE, 8'h08);
		w(A_CTRL, 8'h18);
		w(A_CTRL, 8'h00);
		rchk(A_CTRL, 8'h08);
		w(A_CAUSE, 8'h00);
		w(A_CTRL, 8'h18);
		w(A_CTRL, 8'h00);
		rchk(A_CTRL, 8'h00);
		// interrupt mode with early warning
		w(A_CKD, 8'h04);
		w(A_CTRL, 8'h18);
		w(A_CTRL, 8'h40);
		w(A_CMD, 8'h01);
		wait_out(0, 9000, n);
		chk(32'(n >= 8180 && n <= 8210), 32'h1);
		rchk(A_CKD, 8'h0C);
		// clear mode set: the vector leaves the early flag standing
		w(A_CKD, 8'h24);
		w(A_CMD, 8'h04);
		rchk(A_CKD, 8'h2C);
		w(A_CKD, 8'h08);
		wait_out(0, 9000, n);
		chk(32'(n >= 8100 && n <= 8200), 32'h1);
		rchk(A_CTRL, 8'hC0);
		rchk(A_CAUSE, 8'h00);
		// combined mode: interrupt first, vector drops to reset mode
		w(A_CTRL, 8'h18);
		w(A_CTRL, 8'hC8);
		w(A_CMD, 8'h01);
		wait_out(0, 16600, n);
		chk(32'(n >= 16370 && n <= 16400), 32'h1);
		rchk(A_CAUSE, 8'h00);
		w(A_CMD, 8'h02);
		rchk(A_CTRL, 8'h08);
		chk(32'(guard_irq), 32'h0);
		// the next double time-out now resets the system
		w(A_CMD, 8'h01);
		wait_out(1, 16600, n);
		chk(32'(n >= 16370 && n <= 16400), 32'h1);
		chk(32'(guard_irq), 32'h0);
		// fuse forces reset mode whatever is written
		always_on_fuse <= 1'b1;
		w(A_CTRL, 8'h18);
		w(A_CTRL, 8'h40);
		rd(A_CTRL, d);
		chk(d & 32'h48, 32'h08);
		finish_test();
	end
endmodule
